// *** src/host_port_consts.svh ***
`ifndef HOST_PORT_CONSTS_SVH
`define HOST_PORT_CONSTS_SVH

// ----------------------------------------
// timing
// ----------------------------------------
`define CLOCK_PERIOD_NS  20
`define RESET_MIN_NS     300
`define RESET_MIN_CYCLES ((`RESET_MIN_NS + (`CLOCK_PERIOD_NS) - 1) / (`CLOCK_PERIOD_NS))

// ----------------------------------------
// serial port framing
// ----------------------------------------
`define SPI_BYTE_BITS    8
`define SPI_BIT_CNT_W    3

// ----------------------------------------
// event vector layout
// ----------------------------------------
`define EV_LOCK          0
`define EV_HOLD          1
`define EV_EXT_BASE      2
`define EV_EXT_W         4

`endif

// *** src/host_port_pkg.sv ***
package host_port_pkg;

  // strap decoded into the port in use
  typedef enum logic {
    mode_spi,
    mode_i2c
  } bus_mode_t;

  // strap monitor progress
  typedef enum logic [1:0] {
    st_capture,
    st_run,
    st_fault
  } strap_state_t;

  // raw spi pins handed to the spi engine
  typedef struct packed {
    logic sck;
    logic mosi;
    logic cs_n;
  } spi_side_t;

  // synchronised i2c pins handed to the i2c engine
  typedef struct packed {
    logic scl;
    logic sda;
    logic bus_addr_bit0;
  } i2c_side_t;

  // loop state reported by the dpll
  typedef struct packed {
    logic freq_locked;
    logic phase_locked;
    logic holdover;
  } dpll_status_t;

endpackage

// *** src/sync2.sv ***
`timescale 1ns/100ps
`default_nettype none

module sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_sync;

  // ----------------------------------------
  // two stage synchroniser
  // ----------------------------------------
  // first stage feeds only the second
  always_comb begin
    next_meta = async_in;
    next_sync = meta;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      meta     <= '0;
      sync_out <= '0;
    end else begin
      meta     <= next_meta;
      sync_out <= next_sync;
    end
  end

endmodule

`default_nettype wire

// *** src/status_change_irq.sv ***
`timescale 1ns/100ps
`default_nettype none

module status_change_irq
  import host_port_pkg::*;
#(
  parameter int EV_W = 6
) (
  input  wire logic            clock,
  input  wire logic            rst,
  input  wire logic [EV_W-1:0] event_pulse,
  input  wire logic [EV_W-1:0] event_enable,
  input  wire logic [EV_W-1:0] event_clear,
  output logic      [EV_W-1:0] pending,
  output logic                 irq_active
);

  logic [EV_W-1:0] next_pending;
  logic            next_irq_active;

  // ----------------------------------------
  // sticky status, set beats clear
  // ----------------------------------------
  // a masked event is still recorded so the host can poll it
  always_comb begin
    next_pending    = (pending & ~event_clear) | event_pulse;
    next_irq_active = |(next_pending & event_enable);
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      pending    <= '0;
      irq_active <= 1'b0;
    end else begin
      pending    <= next_pending;
      irq_active <= next_irq_active;
    end
  end

endmodule

`default_nettype wire

// *** src/host_port_mux_and_status.sv ***
// Contract
// - strap high picks i2c, low picks spi
// - clock pin is spi clock or i2c clock
// - data pin is spi input or i2c data
// - output pin carries spi read data only
// - select pin is chip select or address bit
// - open-drain interrupt pulled low on change
// - lock high when frequency and phase locked
// - hold high while loop is in holdover
`timescale 1ns/100ps
`default_nettype none
`include "host_port_consts.svh"

module host_port_mux_and_status
  import host_port_pkg::*;
#(
  parameter int EXT_W = `EV_EXT_W
) (
  input  wire logic               clock,
  input  wire logic               rst,
  input  wire logic               i2c_en_pin,
  input  wire logic               sck_scl_in,
  output logic                    sck_scl_out,
  output logic                    sck_scl_oe_n,
  input  wire logic               si_sda_in,
  output logic                    si_sda_out,
  output logic                    si_sda_oe_n,
  output logic                    so_out,
  input  wire logic               select_or_addr0_pin,
  input  wire logic               irq_in,
  output logic                    irq_out,
  output logic                    irq_oe_n,
  output logic                    lock_out,
  output logic                    hold_out,
  input  wire dpll_status_t       dpll_status,
  input  wire logic [EXT_W-1:0]   ext_event,
  input  wire logic [EXT_W+1:0]   irq_enable,
  input  wire logic [EXT_W+1:0]   irq_clear,
  output logic      [EXT_W+1:0]   irq_status_regs,
  output logic                    irq_line_low,
  output spi_side_t               spi_side,
  input  wire logic               spi_read_bit,
  output i2c_side_t               i2c_side,
  input  wire logic               i2c_scl_hold,
  input  wire logic               i2c_sda_low,
  output bus_mode_t               bus_mode,
  output logic                    spi_byte_done,
  output logic                    spi_busy,
  output logic                    i2c_busy,
  output logic                    strap_fault,
  output logic                    reset_short
);

  localparam int EV_W = EXT_W + 2;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // rising edge of a registered level
  function automatic logic rose(input logic now, input logic was);
    rose = now & ~was;
  endfunction

  // either edge of a registered level
  function automatic logic moved(input logic now, input logic was);
    moved = now ^ was;
  endfunction

  // ----------------------------------------
  // pin function mapping
  // ----------------------------------------
  logic i2c_mode;
  assign i2c_mode = i2c_en_pin;

  // spi engine sees raw pins; it runs on the serial clock itself
  always_comb begin
    spi_side.sck  = i2c_mode ? 1'b0 : sck_scl_in;
    spi_side.mosi = i2c_mode ? 1'b0 : si_sda_in;
    spi_side.cs_n = i2c_mode ? 1'b1 : select_or_addr0_pin;
  end

  // i2c lines only ever pull low; the board pull-up makes the high
  assign sck_scl_out  = 1'b0;
  assign si_sda_out   = 1'b0;
  assign sck_scl_oe_n = ~(i2c_mode & i2c_scl_hold);
  assign si_sda_oe_n  = ~(i2c_mode & i2c_sda_low);

  // ----------------------------------------
  // pin synchronisers into the device clock
  // ----------------------------------------
  logic [4:0] pins_raw;
  logic [4:0] pins_sync;
  logic       strap_sync;
  logic       scl_sync;
  logic       sda_sync;
  logic       addr_sync;
  logic       irq_sync;

  // pins go straight into the flops; no gate sits between a pin and its first stage
  assign pins_raw = {i2c_en_pin, sck_scl_in, si_sda_in, select_or_addr0_pin, irq_in};

  sync2 #(
    .WIDTH (5)
  ) u_pin_sync (
    .clock    (clock),
    .rst      (rst),
    .async_in (pins_raw),
    .sync_out (pins_sync)
  );

  assign {strap_sync, scl_sync, sda_sync, addr_sync, irq_sync} = pins_sync;

  // i2c engine works in the device clock, so it gets the clean copies
  always_comb begin
    i2c_side.scl           = i2c_mode ? scl_sync  : 1'b1;
    i2c_side.sda           = i2c_mode ? sda_sync  : 1'b1;
    i2c_side.bus_addr_bit0 = i2c_mode ? addr_sync : 1'b0;
  end

  assign spi_busy     = ~addr_sync & ~strap_sync;
  assign irq_line_low = ~irq_sync;

  // ----------------------------------------
  // serial clock domain
  // ----------------------------------------
  // counts bits of a spi frame; chip select high ends the frame, so no
  // edge outside a frame is needed to return the counter to zero
  logic [`SPI_BIT_CNT_W-1:0] bit_cnt;
  logic [`SPI_BIT_CNT_W-1:0] next_bit_cnt;
  logic                      byte_tgl;
  logic                      next_byte_tgl;
  logic                      spi_frame_n;

  assign spi_frame_n = select_or_addr0_pin | i2c_en_pin;

  always_comb begin
    next_bit_cnt  = bit_cnt + `SPI_BIT_CNT_W'(1);
    next_byte_tgl = byte_tgl;
    if (bit_cnt == `SPI_BIT_CNT_W'(`SPI_BYTE_BITS - 1)) begin
      next_byte_tgl = ~byte_tgl;
    end
  end

  always_ff @(posedge sck_scl_in or posedge spi_frame_n) begin
    if (spi_frame_n) begin
      bit_cnt <= '0;
    end else begin
      bit_cnt <= next_bit_cnt;
    end
  end

  // the toggle survives frame ends so every byte is one event
  always_ff @(posedge sck_scl_in or posedge rst) begin
    if (rst) begin
      byte_tgl <= 1'b0;
    end else begin
      byte_tgl <= next_byte_tgl;
    end
  end

  // read data launched on the falling edge, held low outside spi frames
  logic so_bit;
  logic next_so_bit;

  always_comb begin
    next_so_bit = spi_frame_n ? 1'b0 : spi_read_bit;
  end

  always_ff @(negedge sck_scl_in or posedge spi_frame_n) begin
    if (spi_frame_n) begin
      so_bit <= 1'b0;
    end else begin
      so_bit <= next_so_bit;
    end
  end

  assign so_out = so_bit & ~i2c_mode;

  // ----------------------------------------
  // byte event crossing
  // ----------------------------------------
  logic tgl_sync;
  logic tgl_seen;
  logic next_tgl_seen;

  sync2 #(
    .WIDTH (1)
  ) u_tgl_sync (
    .clock    (clock),
    .rst      (rst),
    .async_in (byte_tgl),
    .sync_out (tgl_sync)
  );

  always_comb begin
    next_tgl_seen = tgl_sync;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      tgl_seen <= 1'b0;
    end else begin
      tgl_seen <= next_tgl_seen;
    end
  end

  assign spi_byte_done = moved(tgl_sync, tgl_seen);

  // ----------------------------------------
  // i2c start and stop tracking
  // ----------------------------------------
  logic sda_was;
  logic next_sda_was;
  logic next_i2c_busy;

  always_comb begin
    next_sda_was  = sda_sync;
    next_i2c_busy = i2c_busy;
    if (!strap_sync) begin
      next_i2c_busy = 1'b0;
    end else if (scl_sync && rose(sda_was, sda_sync)) begin
      next_i2c_busy = 1'b1; // start
    end else if (scl_sync && rose(sda_sync, sda_was)) begin
      next_i2c_busy = 1'b0; // stop
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      sda_was  <= 1'b1;
      i2c_busy <= 1'b0;
    end else begin
      sda_was  <= next_sda_was;
      i2c_busy <= next_i2c_busy;
    end
  end

  // ----------------------------------------
  // strap monitor
  // ----------------------------------------
  // strap may move while idle; moving mid transfer is flagged until reset
  strap_state_t strap_state;
  strap_state_t next_strap_state;
  bus_mode_t    next_bus_mode;

  always_comb begin
    next_strap_state = strap_state;
    next_bus_mode    = bus_mode;
    case (strap_state)
      st_capture: begin
        next_bus_mode    = strap_sync ? mode_i2c : mode_spi;
        next_strap_state = st_run;
      end
      st_run: begin
        // busy judged by the mode in force; spi_busy drops with the strap itself
        if ((strap_sync != (bus_mode == mode_i2c)) &&
            (((bus_mode == mode_spi) && !addr_sync) || i2c_busy)) begin
          next_strap_state = st_fault;
        end else begin
          next_bus_mode = strap_sync ? mode_i2c : mode_spi;
        end
      end
      st_fault: begin
        next_bus_mode = strap_sync ? mode_i2c : mode_spi;
      end
      default: begin
        next_strap_state = st_capture;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      strap_state <= st_capture;
      bus_mode    <= mode_spi;
    end else begin
      strap_state <= next_strap_state;
      bus_mode    <= next_bus_mode;
    end
  end

  assign strap_fault = (strap_state == st_fault);

  // ----------------------------------------
  // reset length check
  // ----------------------------------------
  // the device relies on a long enough reset; a short one is reported
  logic [`RESET_MIN_CYCLES-1:0] rst_hist;
  logic [`RESET_MIN_CYCLES-1:0] next_rst_hist;
  logic                         next_reset_short;

  // a shift history, not a counter: it needs no reset, and any reset
  // long enough flushes its unknown start value out
  always_comb begin
    next_rst_hist    = {rst_hist[`RESET_MIN_CYCLES-2:0], rst};
    next_reset_short = reset_short;
    if (rst) begin
      next_reset_short = 1'b0;
    end else if (rst_hist[0]) begin
      next_reset_short = ~&rst_hist;
    end
  end

  // history deliberately runs through reset to time it
  always_ff @(posedge clock) begin
    rst_hist    <= next_rst_hist;
    reset_short <= next_reset_short;
  end

  // ----------------------------------------
  // status indicators
  // ----------------------------------------
  logic next_lock;
  logic next_hold;

  always_comb begin
    next_lock = dpll_status.freq_locked & dpll_status.phase_locked;
    next_hold = dpll_status.holdover;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      lock_out <= 1'b0;
      hold_out <= 1'b0;
    end else begin
      lock_out <= next_lock;
      hold_out <= next_hold;
    end
  end

  // ----------------------------------------
  // status change interrupt
  // ----------------------------------------
  logic [EV_W-1:0] events;
  logic            irq_active;

  always_comb begin
    events                = '0;
    events[`EV_LOCK]      = moved(next_lock, lock_out);
    events[`EV_HOLD]      = moved(next_hold, hold_out);
    events[EV_W-1:`EV_EXT_BASE] = ext_event;
  end

  // host learns the cause by reading these after the line falls
  status_change_irq #(
    .EV_W (EV_W)
  ) u_irq (
    .clock        (clock),
    .rst          (rst),
    .event_pulse  (events),
    .event_enable (irq_enable),
    .event_clear  (irq_clear),
    .pending      (irq_status_regs),
    .irq_active   (irq_active)
  );

  assign irq_out  = 1'b0;
  assign irq_oe_n = ~irq_active;

endmodule

`default_nettype wire

// *** bench/host_port_asserts.sv ***
`timescale 1ns/100ps
`default_nettype none

module host_port_asserts
  import host_port_pkg::*;
#(
  parameter int EXT_W = 4
) (
  input wire logic             clock,
  input wire logic             rst,
  input wire logic             i2c_en_pin,
  input wire logic             sck_scl_in,
  input wire logic             si_sda_in,
  input wire logic             select_or_addr0_pin,
  input wire logic             sck_scl_out,
  input wire logic             sck_scl_oe_n,
  input wire logic             si_sda_out,
  input wire logic             si_sda_oe_n,
  input wire logic             so_out,
  input wire logic             irq_out,
  input wire logic             irq_oe_n,
  input wire logic             lock_out,
  input wire logic             hold_out,
  input wire dpll_status_t     dpll_status,
  input wire logic [EXT_W-1:0] ext_event,
  input wire logic [EXT_W+1:0] irq_enable,
  input wire logic [EXT_W+1:0] irq_clear,
  input wire logic [EXT_W+1:0] irq_status_regs,
  input wire spi_side_t        spi_side,
  input wire logic             i2c_scl_hold,
  input wire logic             i2c_sda_low
);
  // ------------------------------------
  // timing checks, one clock domain only
  // ------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  sequence locked_now;
    dpll_status.freq_locked && dpll_status.phase_locked;
  endsequence
  // two samples so a same-edge enable change cannot false-fire
  sequence irq_asked;
    (|(irq_status_regs & irq_enable)) [*2];
  endsequence

  chk_lock_high: assert property (locked_now |=> lock_out)
    else $error("lock low while loop locked");
  chk_lock_low: assert property (!(dpll_status.freq_locked && dpll_status.phase_locked) |=> !lock_out)
    else $error("lock high while loop unlocked");
  chk_hold_high: assert property (dpll_status.holdover [*2] |-> hold_out)
    else $error("hold low during holdover");
  chk_spi_map: assert property (!i2c_en_pin |-> spi_side ==
    {sck_scl_in, si_sda_in, select_or_addr0_pin} && sck_scl_oe_n && si_sda_oe_n)
    else $error("spi pin mapping wrong");
  chk_i2c_map: assert property (i2c_en_pin |-> spi_side == 3'b001 &&
    sck_scl_oe_n == !i2c_scl_hold && si_sda_oe_n == !i2c_sda_low)
    else $error("i2c pin mapping wrong");
  chk_so_unused: assert property (i2c_en_pin |-> so_out == 1'b0)
    else $error("serial output active in i2c mode");
  chk_od_levels: assert property (!sck_scl_out && !si_sda_out && !irq_out)
    else $error("open-drain pin drives high");
  chk_ext_capture: assert property (|ext_event |=>
    (irq_status_regs[EXT_W+1:2] & $past(ext_event)) == $past(ext_event))
    else $error("event not captured");
  chk_pend_sticky: assert property (1 |=>
    ($past(irq_status_regs) & ~$past(irq_clear) & ~irq_status_regs) == '0)
    else $error("pending bit lost without clear");
  chk_irq_drive: assert property (irq_asked |-> !irq_oe_n)
    else $error("interrupt not driven");
  chk_irq_quiet: assert property ((irq_status_regs == '0) [*2] |-> irq_oe_n)
    else $error("interrupt driven with nothing pending");
endmodule

bind host_port_mux_and_status host_port_asserts #(.EXT_W(EXT_W)) u_chk (
  .clock, .rst, .i2c_en_pin, .sck_scl_in, .si_sda_in, .select_or_addr0_pin,
  .sck_scl_out, .sck_scl_oe_n, .si_sda_out, .si_sda_oe_n, .so_out, .irq_out,
  .irq_oe_n, .lock_out, .hold_out, .dpll_status, .ext_event, .irq_enable,
  .irq_clear, .irq_status_regs, .spi_side, .i2c_scl_hold, .i2c_sda_low
);

`default_nettype wire

// *** bench/host_model.sv ***
`timescale 1ns/100ps
`default_nettype none

module host_model (
  output logic sck,
  output logic mosi,
  output logic cs_n,
  output logic scl_low,
  output logic sda_low
);
  // ------------------------------------
  // idle: link clock parked, lines released
  // ------------------------------------
  initial begin
    sck = 1'b0;
    mosi = 1'b0;
    cs_n = 1'b1;
    scl_low = 1'b0;
    sda_low = 1'b0;
  end

  // two bytes under one select, msb first, 30 ns link clock
  task automatic spi_frame(input logic [15:0] data);
    cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      mosi = data[i];
      #15 sck = 1'b1;
      #15 sck = 1'b0;
    end
    #15 cs_n = 1'b1;
    mosi = ~mosi;  // released line must not look still driven
  endtask

  // sda falls while scl is high
  task automatic i2c_start;
    #100 sda_low = 1'b1;
    #100 scl_low = 1'b1;
  endtask

  // sda rises while scl is high
  task automatic i2c_stop;
    #100 scl_low = 1'b0;
    #100 sda_low = 1'b0;
  endtask

  // select pin doubles as address bit in i2c mode
  task automatic set_addr(input logic a);
    cs_n = a;
  endtask
endmodule

`default_nettype wire

// *** bench/tb.sv ***
`timescale 1ns/100ps
`default_nettype none

`define CHECK(nm, exp, got) begin \
  comparisons++; \
  if ((got) !== (exp)) begin \
    error_cnt++; \
    $display("Error %s expected %h seen %h", nm, exp, got); \
  end \
end

module tb
  import host_port_pkg::*;
;
  // ------------------------------------
  // signals
  // ------------------------------------
  logic         clock, rst, i2c_en_pin, spi_read_bit, i2c_scl_hold, i2c_sda_low;
  logic         sck, mosi, cs_n, scl_low, sda_low, so_out;
  logic         sck_scl_out, sck_scl_oe_n, si_sda_out, si_sda_oe_n;
  logic         irq_out, irq_oe_n, lock_out, hold_out, irq_line_low;
  logic         spi_byte_done, spi_busy, i2c_busy, strap_fault, reset_short;
  logic [3:0]   ext_event;
  logic [5:0]   irq_enable, irq_clear, irq_status_regs;
  dpll_status_t dpll_status;
  spi_side_t    spi_side;
  i2c_side_t    i2c_side;
  bus_mode_t    bus_mode;
  int           error_cnt, comparisons, done_cnt;
  wire          sck_pin, sda_pin, irq_wire;

  // pull-ups win unless some party pulls low
  assign sck_pin = i2c_en_pin ? !(scl_low || !sck_scl_oe_n) : sck;
  assign sda_pin = i2c_en_pin ? !(sda_low || !si_sda_oe_n) : mosi;
  assign irq_wire = irq_oe_n ? 1'b1 : irq_out;

  host_port_mux_and_status u_dut (
    .clock, .rst, .i2c_en_pin, .sck_scl_in(sck_pin), .sck_scl_out, .sck_scl_oe_n,
    .si_sda_in(sda_pin), .si_sda_out, .si_sda_oe_n, .so_out, .select_or_addr0_pin(cs_n),
    .irq_in(irq_wire), .irq_out, .irq_oe_n, .lock_out, .hold_out, .dpll_status,
    .ext_event, .irq_enable, .irq_clear, .irq_status_regs, .irq_line_low, .spi_side,
    .spi_read_bit, .i2c_side, .i2c_scl_hold, .i2c_sda_low, .bus_mode, .spi_byte_done,
    .spi_busy, .i2c_busy, .strap_fault, .reset_short
  );
  host_model u_host (.sck, .mosi, .cs_n, .scl_low, .sda_low);

  // 50 MHz device clock
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // byte completions counted as they pulse
  always @(posedge clock) begin
    if (spi_byte_done) done_cnt++;
  end

  // ------------------------------------
  // tasks
  // ------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // host reads pending bits and clears what it saw
  task automatic service_irq;
    irq_clear = irq_status_regs;
    step(1);
    irq_clear = 6'h00;
    step(2);
    `CHECK("pending", 6'h00, irq_status_regs)
    `CHECK("irq wire", 1'b1, irq_wire)
  endtask

  task automatic test_status;
    irq_enable = 6'h3f;
    dpll_status = 3'b100;
    step(2);
    `CHECK("lock freq only", 1'b0, lock_out)
    dpll_status.phase_locked = 1'b1;
    step(1);
    `CHECK("lock", 1'b1, lock_out)
    step(1);
    `CHECK("lock pending", 1'b1, irq_status_regs[0])
    `CHECK("irq low", 1'b0, irq_wire)
    step(2);
    `CHECK("irq seen", 1'b1, irq_line_low)
    service_irq();
    dpll_status = 3'b001;
    step(1);
    `CHECK("hold", 1'b1, hold_out)
    `CHECK("lock lost", 1'b0, lock_out)
    step(6);
    `CHECK("hold kept", 1'b1, hold_out)
    `CHECK("both pending", 6'h03, irq_status_regs)
    service_irq();
    $display("test_status done");
  endtask

  // masked event, then clear racing a new event
  task automatic test_mask;
    irq_enable = 6'h00;
    ext_event = 4'h2;
    step(1);
    ext_event = 4'h0;
    step(3);
    `CHECK("masked pending", 6'h08, irq_status_regs)
    `CHECK("masked wire", 1'b1, irq_wire)
    irq_enable = 6'h08;
    step(2);
    `CHECK("unmasked wire", 1'b0, irq_wire)
    ext_event = 4'h2;
    irq_clear = 6'h08;
    step(1);
    ext_event = 4'h0;
    irq_clear = 6'h00;
    step(1);
    `CHECK("set beats clear", 6'h08, irq_status_regs)
    service_irq();
    $display("test_mask done");
  endtask

  task automatic test_spi;
    spi_read_bit = 1'b1;
    done_cnt = 0;
    fork
      u_host.spi_frame(16'ha53c);
      begin
        @(negedge sck);
        #2;
        `CHECK("read bit", 1'b1, so_out)
        `CHECK("spi map", {sck, mosi, 1'b0}, spi_side)
      end
    join
    step(8);
    `CHECK("byte count", 2, done_cnt)
    `CHECK("so idle", 1'b0, so_out)
    $display("test_spi done");
  endtask

  // strap moved only while both ports are idle
  task automatic test_i2c;
    i2c_en_pin = 1'b1;
    u_host.set_addr(1'b1);
    step(4);
    `CHECK("mode", mode_i2c, bus_mode)
    `CHECK("spi parked", 3'b001, spi_side)
    `CHECK("so unused", 1'b0, so_out)
    `CHECK("i2c pins", 3'b111, i2c_side)
    i2c_scl_hold = 1'b1;
    i2c_sda_low = 1'b1;
    step(1);
    `CHECK("scl pulled", 1'b0, sck_pin)
    `CHECK("sda pulled", 1'b0, sda_pin)
    i2c_scl_hold = 1'b0;
    i2c_sda_low = 1'b0;
    step(1);
    u_host.i2c_start();
    step(4);
    `CHECK("i2c busy", 1'b1, i2c_busy)
    u_host.i2c_stop();
    step(4);
    `CHECK("i2c idle", 1'b0, i2c_busy)
    `CHECK("no fault", 1'b0, strap_fault)
    i2c_en_pin = 1'b0;
    step(4);
    `CHECK("mode back", mode_spi, bus_mode)
    $display("test_i2c done");
  endtask

  // strap moved under an open spi select, then a short and a full reset
  task automatic test_fault;
    u_host.set_addr(1'b0);
    step(4);
    `CHECK("spi busy", 1'b1, spi_busy)
    i2c_en_pin = 1'b1;
    step(4);
    `CHECK("strap fault", 1'b1, strap_fault)
    i2c_en_pin = 1'b0;
    u_host.set_addr(1'b1);
    step(2);
    `CHECK("fault sticky", 1'b1, strap_fault)
    `CHECK("spi free", 1'b0, spi_busy)
    rst = 1'b1;
    step(3);
    rst = 1'b0;
    step(2);
    `CHECK("short reset", 1'b1, reset_short)
    `CHECK("fault cleared", 1'b0, strap_fault)
    rst = 1'b1;
    step(16);
    rst = 1'b0;
    step(2);
    `CHECK("full reset", 1'b0, reset_short)
    `CHECK("mode after reset", mode_spi, bus_mode)
    $display("test_fault done");
  endtask

  task automatic test_done;
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ------------------------------------
  // main sequence
  // ------------------------------------
  initial begin
    rst = 1'b1;
    {i2c_en_pin, spi_read_bit, i2c_scl_hold, i2c_sda_low} = 4'h0;
    dpll_status = 3'b000;
    ext_event = 4'h0;
    irq_enable = 6'h00;
    irq_clear = 6'h00;
    error_cnt = 0;
    comparisons = 0;
    done_cnt = 0;
    step(16);
    rst = 1'b0;
    step(2);
    `CHECK("reset irq", 1'b1, irq_wire)
    `CHECK("reset length", 1'b0, reset_short)
    test_status();
    test_mask();
    test_spi();
    test_i2c();
    test_fault();
    test_done();
  end

  // tests take a few microseconds; wide margin
  initial begin
    #50000;
    error_cnt++;
    test_done();
  end
endmodule

`default_nettype wire
